// ===== design/ofp_ctrl.sv
`timescale 1ns/10ps
`include "ofp_regs.svh"

module ofp_ctrl #(
    parameter bit SW_OE_OPTION = 1'b1,
    parameter int HOLDOFF_CYC  = `OFP_HOLDOFF_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        spi_sclk_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    output logic             spi_miso_oe_o,
    input  wire logic        pll_lock_i,
    output logic [4:0]       multiplier_integer_o,
    output logic [26:0]      multiplier_fraction_o,
    output logic [12:0]      output_divider_o,
    output logic [1:0]       driver_predivide_factor_o,
    output logic [25:0]      offset_word_o,
    output logic             offset_update_o,
    output logic             divider_update_o,
    output logic [2:0]       swing_div_o,
    output logic [2:0]       swing_prediv_o,
    output logic             driver_enable_o
);

    // -------------------------------------------------------------
    // functions
    // -------------------------------------------------------------
    function automatic logic addr_valid(input logic [6:0] a);
        addr_valid = (a == `OFP_ADDR_PULL_LO) || (a == `OFP_ADDR_PULL_HI)
                  || (a == `OFP_ADDR_MULT_HI) || (a == `OFP_ADDR_MULT_LO)
                  || (a == `OFP_ADDR_OUT_DIV) || (a == `OFP_ADDR_PREDIV);
    endfunction

    // -------------------------------------------------------------
    // link side: frame shifter on the serial clock
    // -------------------------------------------------------------
    logic [4:0]  bit_cnt;
    logic [22:0] rx_shift;
    logic        rd_frame;
    logic [15:0] tx_shift;
    logic [6:0]  lk_wr_addr;
    logic [15:0] lk_wr_data;
    logic        lk_wr_tgl;
    logic        lk_miso;
    logic        lk_miso_oe;
    logic [15:0] rd_word;

    wire  [6:0]  cur_addr   = {rx_shift[5:0], spi_mosi_i};
    wire         addr_done  = (bit_cnt == `OFP_ADDR_LAST);
    wire         frame_done = (bit_cnt == `OFP_FRAME_LAST);

    // chip select high clears the frame to bit zero, so each frame starts fresh
    always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            bit_cnt    <= 5'h00;
            lk_miso_oe <= 1'b0;
        end
        else
        begin
            if (!frame_done)
                bit_cnt <= bit_cnt + 5'h01;
            if (addr_done && rd_frame)
                lk_miso_oe <= 1'b1;
        end
    end

    always_ff @(posedge spi_sclk_i)
    begin
        rx_shift <= {rx_shift[21:0], spi_mosi_i};
        if (bit_cnt == 5'h00)
            rd_frame <= spi_mosi_i;
        if (addr_done)
            tx_shift <= rd_word;
        else
            tx_shift <= {tx_shift[14:0], 1'b0};
        lk_miso <= addr_done ? rd_word[15] : tx_shift[14];
    end

    wire lk_wr_done = frame_done && !spi_cs_n_i && !rx_shift[22];

    // completed write: hold word
    always_ff @(posedge spi_sclk_i)
    begin
        if (lk_wr_done)
        begin
            lk_wr_addr <= rx_shift[21:15];
            lk_wr_data <= {rx_shift[14:0], spi_mosi_i};
        end
    end

    // event toggle; core reset clears it while the link is idle
    always_ff @(posedge spi_sclk_i or posedge srst_i)
    begin
        if (srst_i)
            lk_wr_tgl <= 1'b0;
        else if (lk_wr_done)
            lk_wr_tgl <= ~lk_wr_tgl;
    end

    // -------------------------------------------------------------
    // core side: register file
    // -------------------------------------------------------------
    logic [15:0] regs [0:6];
    logic [2:0]  tgl_sync;
    logic [2:0]  lock_sync;
    logic [6:0]  wr_addr;
    logic [15:0] wr_data;

    // read mux; regs only change on core reset or after a completed write crossing
    assign rd_word = addr_valid(cur_addr) ? regs[cur_addr[2:0]]
                                          : 16'h0000;

    wire wr_evt  = tgl_sync[1] ^ tgl_sync[2];
    wire lock_ok = lock_sync[1] & lock_sync[2];
    wire wr_ok   = wr_evt && addr_valid(lk_wr_addr);

    always_ff @(posedge core_clk_i)
    begin
        tgl_sync  <= {tgl_sync[1:0], lk_wr_tgl};
        lock_sync <= {lock_sync[1:0], pll_lock_i};
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < 7; i++)
                regs[i] <= `OFP_REG_RESET;
        end
        else if (wr_ok)
        begin
            regs[lk_wr_addr[2:0]] <= lk_wr_data;
        end
    end

    // -------------------------------------------------------------
    // core side: write triggers
    // -------------------------------------------------------------
    logic       wr_stb;
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            wr_stb  <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= 16'h0000;
        end
        else
        begin
            wr_stb  <= wr_ok;
            wr_addr <= lk_wr_addr;
            wr_data <= lk_wr_data;
        end
    end

    wire trig_mult = wr_stb && (wr_addr == `OFP_ADDR_MULT_HI);
    wire trig_div  = wr_stb && (wr_addr == `OFP_ADDR_OUT_DIV);
    wire trig_pull = wr_stb && (wr_addr == `OFP_ADDR_PULL_HI);
    wire trig_pre  = wr_stb && (wr_addr == `OFP_ADDR_PREDIV);

    // -------------------------------------------------------------
    // decoded staged values
    // -------------------------------------------------------------
    wire [15:0] r_mult_hi = regs[3];
    wire [15:0] r_mult_lo = regs[4];
    wire [15:0] r_div     = regs[5];
    wire [15:0] r_pre     = regs[6];
    wire [15:0] r_pull_lo = regs[0];
    wire [15:0] r_pull_hi = regs[1];

    wire [4:0]  dec_int  = r_mult_hi[`OFP_MULT_INT_MSB:`OFP_MULT_INT_LSB]
                         ^ `OFP_MULT_INT_MASK;
    wire [26:0] dec_frac = {r_mult_hi[`OFP_MULT_FRAC_HI_MSB:0],
                            r_mult_lo};
    wire [12:0] dec_div  = r_div[15:`OFP_OUT_DIV_LSB]
                         ^ `OFP_OUT_DIV_MASK;
    wire [1:0]  dec_pre  = r_pre[`OFP_PREDIV_SEL_BIT] ? 2'h1
                                                      : 2'h2;
    wire [25:0] dec_pull = {r_pull_hi[`OFP_PULL_HI_MSB:0],
                            r_pull_lo};
    wire        sw_oe    = SW_OE_OPTION ? r_pull_hi[`OFP_SW_OE_BIT]
                                        : 1'b1;

    // -------------------------------------------------------------
    // applied settings
    // -------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            multiplier_integer_o      <= 5'h00;
            multiplier_fraction_o     <= 27'h0000000;
            output_divider_o          <= 13'h0000;
            driver_predivide_factor_o <= 2'h2;
            divider_update_o          <= 1'b0;
        end
        else
        begin
            divider_update_o <= trig_div;
            if (trig_div)
            begin
                multiplier_integer_o      <= dec_int;
                multiplier_fraction_o     <= dec_frac;
                output_divider_o          <= dec_div;
                driver_predivide_factor_o <= dec_pre;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            offset_word_o   <= 26'h0000000;
            offset_update_o <= 1'b0;
        end
        else
        begin
            offset_update_o <= trig_pull;
            if (trig_pull)
                offset_word_o <= dec_pull;
        end
    end

    // swing codes take effect straight after their write
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            swing_div_o    <= 3'h0;
            swing_prediv_o <= 3'h0;
        end
        else
        begin
            if (trig_div)
                swing_div_o <= r_div[`OFP_SWING_MSB:0];
            if (trig_pre)
                swing_prediv_o <= r_pre[`OFP_SWING_MSB:0];
        end
    end

    // -------------------------------------------------------------
    // output driver sequencer
    // -------------------------------------------------------------
    ofp_pkg::ofp_state_t state;
    ofp_pkg::ofp_state_t next_state;
    logic [15:0]         holdoff;
    logic [15:0]         next_holdoff;
    logic                next_drv_en;

    wire holdoff_done = (holdoff == 16'h0000);

    always_comb
    begin
        next_state   = state;
        next_holdoff = (holdoff_done) ? holdoff : holdoff - 16'h0001;
        case (state)
            ofp_pkg::OFP_ST_RUN:
            begin
                if (trig_mult)
                    next_state = ofp_pkg::OFP_ST_HALT;
                else if (trig_div)
                begin
                    next_state   = ofp_pkg::OFP_ST_RELOCK;
                    next_holdoff = HOLDOFF_CYC[15:0];
                end
            end
            ofp_pkg::OFP_ST_HALT:
            begin
                if (trig_div)
                begin
                    next_state   = ofp_pkg::OFP_ST_RELOCK;
                    next_holdoff = HOLDOFF_CYC[15:0];
                end
            end
            ofp_pkg::OFP_ST_RELOCK:
            begin
                if (trig_mult)
                    next_state = ofp_pkg::OFP_ST_HALT;
                else if (trig_div)
                    next_holdoff = HOLDOFF_CYC[15:0];
                else if (holdoff_done && lock_ok)
                    next_state = ofp_pkg::OFP_ST_RUN;
            end
            default:
            begin
                next_state = ofp_pkg::OFP_ST_RUN;
            end
        endcase
    end

    // enable follows next state so it drops on the trigger edge
    assign next_drv_en = (next_state == ofp_pkg::OFP_ST_RUN)
                       && sw_oe;

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            state           <= ofp_pkg::OFP_ST_RUN;
            holdoff         <= 16'h0000;
            driver_enable_o <= SW_OE_OPTION ? 1'b0 : 1'b1;
        end
        else
        begin
            state           <= next_state;
            holdoff         <= next_holdoff;
            driver_enable_o <= next_drv_en;
        end
    end

    // -------------------------------------------------------------
    // link outputs
    // -------------------------------------------------------------
    assign spi_miso_o    = lk_miso;
    assign spi_miso_oe_o = lk_miso_oe;

endmodule

// ===== design/ofp_pkg.sv
package ofp_pkg;

    // -------------------------------------------------------------
    // output driver sequencer states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        OFP_ST_RUN    = 3'b001,
        OFP_ST_HALT   = 3'b010,
        OFP_ST_RELOCK = 3'b100
    } ofp_state_t;

endpackage

// ===== design/ofp_regs.svh
`ifndef OFP_REGS_SVH
`define OFP_REGS_SVH

// -----------------------------------------------------------------
// register indices (serial register number)
// -----------------------------------------------------------------
`define OFP_ADDR_PULL_LO      7'h00
`define OFP_ADDR_PULL_HI      7'h01
`define OFP_ADDR_MULT_HI      7'h03
`define OFP_ADDR_MULT_LO      7'h04
`define OFP_ADDR_OUT_DIV      7'h05
`define OFP_ADDR_PREDIV       7'h06

// -----------------------------------------------------------------
// field positions and masks
// -----------------------------------------------------------------
`define OFP_MULT_INT_MSB      15
`define OFP_MULT_INT_LSB      11
`define OFP_MULT_FRAC_HI_MSB  10
`define OFP_OUT_DIV_LSB       3
`define OFP_PREDIV_SEL_BIT    3
`define OFP_SW_OE_BIT         10
`define OFP_PULL_HI_MSB       9
`define OFP_SWING_MSB         2
`define OFP_MULT_INT_MASK     5'h0E
`define OFP_OUT_DIV_MASK      13'h001B

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define OFP_REG_RESET         16'h0000

// -----------------------------------------------------------------
// serial frame layout and timing
// -----------------------------------------------------------------
`define OFP_FRAME_LAST        5'h17
`define OFP_ADDR_LAST         5'h07
`define OFP_CLK_PERIOD_NS     100
`define OFP_HOLDOFF_NS        1000
`define OFP_HOLDOFF_CYC       ((`OFP_HOLDOFF_NS + `OFP_CLK_PERIOD_NS - 1) / `OFP_CLK_PERIOD_NS)

`endif

// ===== verification/ofp_ctrl_chk.sv
`timescale 1ns/10ps
// ------------------------------------
// port checker
// ------------------------------------
module ofp_ctrl_chk (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        pll_lock_i,
    input  wire logic        spi_miso_oe_o,
    input  wire logic [4:0]  multiplier_integer_o,
    input  wire logic [26:0] multiplier_fraction_o,
    input  wire logic [12:0] output_divider_o,
    input  wire logic [1:0]  driver_predivide_factor_o,
    input  wire logic [25:0] offset_word_o,
    input  wire logic        offset_update_o,
    input  wire logic        divider_update_o,
    input  wire logic [2:0]  swing_div_o,
    input  wire logic        driver_enable_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    start_off_a: assert property (
        $fell(srst_i) |-> !driver_enable_o)
        else $error("output on right after reset");
    relock_off_a: assert property (
        divider_update_o |-> !driver_enable_o ##1 !driver_enable_o)
        else $error("output on during relock");
    lock_first_a: assert property (
        $rose(driver_enable_o) && !offset_update_o
        |-> $past(pll_lock_i, 2))
        else $error("output on without lock");
    div_pulse_a: assert property (
        divider_update_o |=> !divider_update_o)
        else $error("divider pulse too long");
    off_pulse_a: assert property (
        offset_update_o |=> !offset_update_o)
        else $error("offset pulse too long");
    off_hold_a: assert property (
        !offset_update_o |-> $stable(offset_word_o))
        else $error("offset word moved without trigger");
    div_hold_a: assert property (
        !divider_update_o |-> $stable({multiplier_integer_o,
        multiplier_fraction_o, output_divider_o,
        driver_predivide_factor_o, swing_div_o}))
        else $error("dividers moved without trigger");
    prediv_code_a: assert property (
        driver_predivide_factor_o == 2'h1
        || driver_predivide_factor_o == 2'h2)
        else $error("illegal predivide factor");
    miso_sel_a: assert property (
        spi_miso_oe_o |-> !spi_cs_n_i)
        else $error("read data driven while idle");
endmodule
bind ofp_ctrl ofp_ctrl_chk ofp_ctrl_chk_inst (.*);

// ===== verification/ofp_host.sv
`timescale 1ns/10ps
// ------------------------------------
// serial host model
// ------------------------------------
module ofp_host (
    output logic      spi_sclk_o,
    output logic      spi_cs_n_o,
    output logic      spi_mosi_o,
    input  wire logic spi_miso_i
);
    initial
    begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b0;
        spi_mosi_o = 1'b0;
        // idle edge clears the frame counter
        #1 spi_cs_n_o = 1'b1;
    end
    // one 24-bit frame, msb first, clock only inside the frame
    task automatic frame(input logic [7:0] hd, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [23:0] sh;
        sh = {hd, wd};
        rd = 16'h0000;
        spi_cs_n_o = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            spi_mosi_o = sh[23 - i];
            #15;
            if (i > 7)
                rd = {rd[14:0], spi_miso_i};
            spi_sclk_o = 1'b1;
            #15;
            spi_sclk_o = 1'b0;
        end
        #15;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
    endtask
endmodule

// ===== verification/tb_osc_frequency_program_regs.sv
`timescale 1ns/10ps
// ------------------------------------
// bench
// ------------------------------------
module tb_osc_frequency_program_regs;
    logic        core_clk_i = 1'b0;
    logic        srst_i     = 1'b0;
    logic        pll_lock_i = 1'b0;
    logic        spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o;
    logic        spi_miso_oe_o, offset_update_o, divider_update_o;
    logic        driver_enable_o, upd_seen, off_seen;
    logic [4:0]  multiplier_integer_o, mi;
    logic [26:0] multiplier_fraction_o, mf;
    logic [12:0] output_divider_o, od;
    logic [1:0]  driver_predivide_factor_o;
    logic [25:0] offset_word_o;
    logic [2:0]  swing_div_o, swing_prediv_o, s5, s6;
    logic [31:0] seed = 32'h4EE4F82F, v;
    logic [15:0] lo;
    logic [9:0]  hi;
    logic        ps;
    int          miscompares = 0, samples_checked = 0, n;
    initial
    begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    ofp_ctrl #(.HOLDOFF_CYC(4)) ofp_ctrl_inst (.*);
    ofp_host ofp_host_inst (.spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i),
        .spi_mosi_o(spi_mosi_i), .spi_miso_i(spi_miso_o));
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [15:0] w3(input logic [4:0] i, input logic [26:0] f);
        return {i ^ 5'h0E, f[26:16]};
    endfunction
    // host divider search and encoding, lowest multiplier wins
    function automatic void pick(input real f, input bit hi_var,
        output logic [12:0] d, output logic p, output logic [4:0] ip,
        output logic [26:0] fp);
        real m;
        real best;
        best = 99.0;
        d = 13'h0000;
        p = 1'b0;
        for (int k = 2; k < 8192; k++)
        begin
            m = f * 2.0 * k / 188.0;
            if (best > 90.0 && m >= 13.08511 && m <= 15.96875)
            begin
                best = m;
                d = k[12:0];
            end
        end
        for (int k = 3; k < 8; k += 2)
        begin
            m = f * k / 188.0;
            if (hi_var && m >= 13.08511 && m <= 15.96875 && m < best)
            begin
                best = m;
                d = k[12:0];
                p = 1'b1;
            end
        end
        ip = 5'($rtoi(best));
        fp = 27'($rtoi((best - ip) * 134217728.0 + 0.5));
    endfunction
    // host offset word, rounded to nearest
    function automatic logic [25:0] off_word(input real req, input real rng);
        real x;
        x = req / rng * 33554432.0 - 1.0;
        return 26'($rtoi(x < 0.0 ? x - 0.5 : x + 0.5));
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checked %0d wrong %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // write, then watch the update pulses while it crosses
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] r;
        upd_seen = 1'b0;
        off_seen = 1'b0;
        @(negedge core_clk_i);
        ofp_host_inst.frame({1'b0, a}, d, r);
        repeat (8)
        begin
            @(negedge core_clk_i);
            upd_seen = upd_seen | (divider_update_o === 1'b1);
            off_seen = off_seen | (offset_update_o === 1'b1);
        end
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] r;
        @(negedge core_clk_i);
        ofp_host_inst.frame({1'b1, a}, 16'h0000, r);
        chk(r, e);
        @(negedge core_clk_i);
        chk(spi_miso_oe_o, 32'h0);
    endtask
    initial
    begin
        #1 srst_i = 1'b1;
        repeat (20) @(negedge core_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        chk(driver_enable_o, 32'h0);
        chk(driver_predivide_factor_o, 32'h2);
        rdchk(7'h01, 16'h0000);
        for (int i = 0; i < 9; i++)
        begin
            v = xs();
            n = (i == 8) ? 127 : i;
            wr(n[6:0], v[15:0]);
            rdchk(n[6:0], (n inside {0, 1, 3, 4, 5, 6}) ? v[15:0] : 0);
        end
        $display("test readback done");
        pick(156.25, 1'b0, od, ps, mi, mf);
        chk(od, 32'h8);
        chk(mi, 32'hD);
        chk(mf, 32'h2620AE5);
        pick(500.0, 1'b1, od, ps, mi, mf);
        chk(od, 32'h5);
        chk(ps, 32'h1);
        pick(622.08, 1'b1, od, ps, mi, mf);
        chk(od, 32'h2);
        chk(ps, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            v = xs();
            mi = (i == 0) ? 5'h0D : 5'h0D + v[1:0] % 3;
            mf = (i == 0) ? 27'd39979435 : v[31:5];
            od = (i == 0) ? 13'h0008 : 13'h0002 + xs() % 8190;
            ps = (i == 0) ? 1'b0 : v[2];
            s5 = (i == 0) ? 3'h6 : (i == 1) ? 3'h5 : (i == 2) ? 3'h1 : 3'h0;
            s6 = i[1] ? 3'h0 : 3'h6;
            if (i == 0)
                chk(w3(mi, mf), 32'h1A62);
            pll_lock_i = 1'b1;
            wr(7'h01, 16'h0400);
            chk(driver_enable_o, 32'h1);
            pll_lock_i = 1'b0;
            wr(7'h03, w3(mi, mf));
            chk(driver_enable_o, 32'h0);
            wr(7'h04, mf[15:0]);
            wr(7'h06, {12'h000, ps, s6});
            chk(upd_seen, 32'h0);
            chk(swing_prediv_o, s6);
            rdchk(7'h06, {12'h000, ps, s6});
            wr(7'h05, {od ^ 13'h001B, s5});
            chk(upd_seen, 32'h1);
            chk(multiplier_integer_o, mi);
            chk(multiplier_fraction_o, mf);
            chk(output_divider_o, od);
            chk(driver_predivide_factor_o, ps ? 32'h1 : 32'h2);
            chk(swing_div_o, s5);
            chk(driver_enable_o, 32'h0);
            pll_lock_i = 1'b1;
            n = 0;
            while (driver_enable_o !== 1'b1 && n < 40)
            begin
                @(negedge core_clk_i);
                n++;
            end
            if (n == 40)
            begin
                miscompares++;
                final_report();
            end
            chk(driver_enable_o, 32'h1);
        end
        $display("test divider program done");
        for (int i = 0; i < 3; i++)
        begin
            v = xs();
            lo = (i == 0) ? 16'hFFFF : v[15:0];
            hi = (i == 0) ? 10'h3FF : v[25:16];
            if (i == 1)
            begin
                {hi, lo} = off_word(-25.0, 100.0);
                chk({hi, lo}, 32'h37FFFFF);
            end
            repeat (300) @(negedge core_clk_i);
            wr(7'h00, lo);
            chk(off_seen, 32'h0);
            wr(7'h01, {6'h01, hi});
            chk(off_seen, 32'h1);
            chk(offset_word_o, {hi, lo});
            chk(driver_enable_o, 32'h1);
        end
        wr(7'h01, {6'h00, hi});
        chk(driver_enable_o, 32'h0);
        $display("test offset done");
        final_report();
    end
endmodule
